// ### design/compact_timer_consts.vh
// Constants for the compact timer: APB offsets, control field positions, reset values
`ifndef COMPACT_TIMER_CONSTS_VH
`define COMPACT_TIMER_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CT_OFS_CTRL0 12'h000
`define CT_OFS_CTRL1 12'h004
`define CT_OFS_CNT 12'h008
`define CT_OFS_CMPA 12'h00c
`define CT_OFS_STAT 12'h010

// ----------------------------------------
// Control 0 fields
// ----------------------------------------
`define CT_C0_ON 3
`define CT_C0_RP_HI 2
`define CT_C0_RP_LO 0
`define CT_C0_PRE_HI 7
`define CT_C0_PRE_LO 4

// ----------------------------------------
// Control 1 fields
// ----------------------------------------
`define CT_C1_MODE_HI 7
`define CT_C1_MODE_LO 6
`define CT_C1_IO_HI 5
`define CT_C1_IO_LO 4
`define CT_C1_OC 3
`define CT_C1_POL 2
`define CT_C1_DPX 1
`define CT_C1_CCLR 0

// ----------------------------------------
// Mode and action codes
// ----------------------------------------
`define CT_MODE_CMP 2'b00
`define CT_MODE_PWM 2'b10
`define CT_MODE_TMR 2'b11
`define CT_IO_NONE 2'b00
`define CT_IO_LOW 2'b01
`define CT_IO_HIGH 2'b10
`define CT_IO_TOGGLE 2'b11

// ----------------------------------------
// Reset values and counter limits
// ----------------------------------------
`define CT_CTRL_RST 8'h00
`define CT_CMPA_RST 10'h000
`define CT_CNT_MAX 10'h3ff

`endif

// ### design/tick_divider.v
// Timer clock enable divider: one-cycle pulse every (div_sel+1) pclk cycles
`timescale 1ns/1ps
`default_nettype none

module tick_divider (
	input wire pclk,
	input wire presetn,
	input wire [3:0] div_sel,
	output wire tick
);
	reg [3:0] cnt_r;

	// Free-running count; wraps at the selected divide value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
		end else if (cnt_r >= div_sel) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	assign tick = (cnt_r >= div_sel);
endmodule // tick_divider

`default_nettype wire

// ### design/compact_timer.v
// Compact 10-bit timer: compare-match, timer/counter and PWM modes behind an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"

// Overview of operation
// [R1] Mode 00 selects compare-match output mode
// [R2] Clear select low: clear on P or overflow
// [R3] Clear select high: clear on A, no P
// [R4] Compare A zero: run to 3FF, no A
// [R5] Compare mode pin changes only on A
// [R6] Action bits: high, low, toggle, or hold
// [R7] Counter-on rise loads the initial pin level
// [R8] Mode 11 acts as compare, pin undriven
// [R9] Mode 10 is PWM; clear select ignored
// [R10] One register sets period, other sets duty
// [R11] Swap clear: period code period, A duty
// [R12] Swap set: A period, code duty
// [R13] Duty at or above period gives 100%
// [R14] PWM raises A and P flags on matches
// [R15] Init level active, action force, invert polarity
// [R16] Counting continues while action forces level
// [R17] Counter-on rise zeroes, fall holds counter
// [R18] Period code compares counter top three bits
// [R19] Action codes: none, low, high, toggle
// [R20] Counter increments once per timer tick
module compact_timer (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg timer_out,
	output wire timer_out_en_n
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] ctrl0_r;
	reg [7:0] timer_control_one;
	reg [9:0] compare_a_value;
	reg [9:0] cnt_r;
	reg [9:0] cnt_nxt;
	reg match_a_flag;
	reg match_p_flag;
	reg on_d_r;
	reg pin_r;
	reg pin_nxt;
	reg a_hit;
	reg p_hit;
	reg clr;
	reg wrap;

	wire tick;
	wire counter_on = ctrl0_r[`CT_C0_ON];
	wire [2:0] period_code = ctrl0_r[`CT_C0_RP_HI:`CT_C0_RP_LO];
	wire [1:0] mode_sel = timer_control_one[`CT_C1_MODE_HI:`CT_C1_MODE_LO];
	wire mode_sel_hi = mode_sel[1];
	wire mode_sel_lo = mode_sel[0];
	wire [1:0] out_action = timer_control_one[`CT_C1_IO_HI:`CT_C1_IO_LO];
	wire out_action_hi = out_action[1];
	wire out_action_lo = out_action[0];
	wire out_init_level = timer_control_one[`CT_C1_OC];
	wire out_invert = timer_control_one[`CT_C1_POL];
	wire period_duty_swap = timer_control_one[`CT_C1_DPX];
	wire clear_select = timer_control_one[`CT_C1_CCLR];
	wire on_rise = counter_on & ~on_d_r;
	wire is_pwm = mode_sel_hi & ~mode_sel_lo; // [R9]
	wire is_cmp = ~mode_sel_hi & ~mode_sel_lo; // [R1]
	wire is_tmr = mode_sel_hi & mode_sel_lo; // [R8]

	// ----------------------------------------
	// APB slave: zero wait states, unmapped reads zero and error
	// ----------------------------------------
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire mapped = (paddr == `CT_OFS_CTRL0) || (paddr == `CT_OFS_CTRL1) || (paddr == `CT_OFS_CNT) ||
		(paddr == `CT_OFS_CMPA) || (paddr == `CT_OFS_STAT);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	// Read mux registered at setup so data is stable through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			case (paddr)
				`CT_OFS_CTRL0: prdata <= {24'h00_0000, ctrl0_r};
				`CT_OFS_CTRL1: prdata <= {24'h00_0000, timer_control_one};
				`CT_OFS_CNT: prdata <= {22'h00_0000, cnt_r};
				`CT_OFS_CMPA: prdata <= {22'h00_0000, compare_a_value};
				`CT_OFS_STAT: prdata <= {29'h0000_0000, timer_out, match_p_flag, match_a_flag};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control writes; counter is read only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_r <= `CT_CTRL_RST;
			timer_control_one <= `CT_CTRL_RST;
			compare_a_value <= `CT_CMPA_RST;
		end else if (wr) begin
			if (paddr == `CT_OFS_CTRL0) begin
				ctrl0_r <= pwdata[7:0];
			end
			if (paddr == `CT_OFS_CTRL1) begin
				timer_control_one <= pwdata[7:0];
			end
			if (paddr == `CT_OFS_CMPA) begin
				compare_a_value <= pwdata[9:0];
			end
		end
	end

	// ----------------------------------------
	// Timer clock enable
	// ----------------------------------------
	tick_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.div_sel(ctrl0_r[`CT_C0_PRE_HI:`CT_C0_PRE_LO]),
		.tick(tick)
	);

	// ----------------------------------------
	// Comparators and clear selection
	// ----------------------------------------
	// Matches look at the next count, so a clear gives a period of exactly the
	// programmed value, in line with the 1024 counts of a plain wrap
	wire [9:0] cnt_inc = cnt_r + 10'h001;

	always @* begin
		// Period code only sees counter bits 9..7, so matches land on 128 multiples
		p_hit = (period_code != 3'b000) && (cnt_inc[9:7] == period_code) && (cnt_inc[6:0] == 7'h00); // [R18]
		a_hit = (compare_a_value != 10'h000) && (cnt_inc == compare_a_value); // [R4]
		wrap = (cnt_r == `CT_CNT_MAX);
		if (is_pwm) begin
			// Clear on the period source; duty register does not clear [R9] [R10]
			if (period_duty_swap) begin
				clr = a_hit | wrap; // [R12]
			end else begin
				clr = p_hit | wrap; // [R11]
			end
		end else if (clear_select) begin
			clr = a_hit | wrap; // [R3]
		end else begin
			clr = p_hit | wrap; // [R2]
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always @* begin
		cnt_nxt = cnt_r;
		if (on_rise) begin
			cnt_nxt = 10'h000; // [R17]
		end else if (counter_on & tick) begin
			if (clr) begin
				cnt_nxt = 10'h000;
			end else begin
				cnt_nxt = cnt_inc; // [R20]
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 10'h000;
			on_d_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt; // [R17]
			on_d_r <= counter_on;
		end
	end

	// ----------------------------------------
	// Match flags: hardware set wins over software write-one-to-clear
	// ----------------------------------------
	wire ev = counter_on & tick & ~on_rise;
	wire set_a = ev & a_hit; // [R2] [R14]
	wire set_p = ev & p_hit & (is_pwm | ~clear_select); // [R3] [R14]
	wire clr_flags = wr && (paddr == `CT_OFS_STAT);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_a_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end else begin
			match_a_flag <= set_a | (match_a_flag & ~(clr_flags & pwdata[0]));
			match_p_flag <= set_p | (match_p_flag & ~(clr_flags & pwdata[1]));
		end
	end

	// ----------------------------------------
	// Compare-mode pin state
	// ----------------------------------------
	always @* begin
		pin_nxt = pin_r;
		if (on_rise) begin
			pin_nxt = out_init_level; // [R7]
		end else if (set_a) begin
			// Only comparator A moves the pin; P matches are ignored [R5]
			case (out_action)
				`CT_IO_LOW: pin_nxt = 1'b0; // [R19]
				`CT_IO_HIGH: pin_nxt = 1'b1; // [R6]
				`CT_IO_TOGGLE: pin_nxt = ~pin_r; // [R6]
				default: pin_nxt = pin_r; // [R19]
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	// ----------------------------------------
	// PWM waveform
	// ----------------------------------------
	// Duty and period in counts; duty >= period holds the output active
	wire [10:0] code_cnt = (period_code == 3'b000) ? 11'h400 : {1'b0, period_code, 7'h00};
	wire [10:0] per_v = period_duty_swap ? {1'b0, compare_a_value} : code_cnt;
	wire [10:0] duty_v = period_duty_swap ? code_cnt : {1'b0, compare_a_value};
	wire pwm_act = (duty_v >= per_v) | ({1'b0, cnt_r} < duty_v); // [R13]
	reg pwm_lvl;

	// Waveform keeps running underneath forced levels [R16]
	always @* begin
		case ({out_action_hi, out_action_lo})
			`CT_IO_NONE: pwm_lvl = ~out_init_level; // [R15]
			`CT_IO_LOW: pwm_lvl = out_init_level; // [R15]
			`CT_IO_HIGH: pwm_lvl = pwm_act ? out_init_level : ~out_init_level; // [R15]
			default: pwm_lvl = ~out_init_level;
		endcase
	end

	// ----------------------------------------
	// Output pin, registered; released in timer/counter mode
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_out <= 1'b0;
		end else if (is_pwm) begin
			timer_out <= pwm_lvl ^ out_invert; // [R15]
		end else begin
			timer_out <= pin_r ^ out_invert;
		end
	end

	// Low while driving; mode 01 is undefined and also leaves the pin free
	assign timer_out_en_n = ~(is_pwm | is_cmp) | is_tmr; // [R8]
endmodule // compact_timer

`default_nettype wire

// ### tb/compact_timer_asserts.sv
// Port-level assertions for the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"
module compact_timer_asserts (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire timer_out,
	input wire timer_out_en_n
);
	reg [7:0] c1_r;
	reg on_r;
	reg [1:0] calm_r;
	wire wr = psel && penable && pwrite && pready;
	wire [1:0] md = c1_r[7:6];
	wire [1:0] io = c1_r[5:4];
	wire oc = c1_r[3];
	wire pol = c1_r[2];
	// Pin checks wait three edges after a control write, since the pin is registered twice
	wire hold = (calm_r == 2'd3) && on_r;
	// --------------------------------
	// Shadow of the control bits
	// --------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c1_r <= 8'h00;
			on_r <= 1'b0;
			calm_r <= 2'd0;
		end else begin
			if (wr && paddr == `CT_OFS_CTRL1) c1_r <= pwdata[7:0];
			if (wr && paddr == `CT_OFS_CTRL0) on_r <= pwdata[3];
			calm_r <= (wr && paddr[11:3] == 9'h000) ? 2'd0 : ((calm_r == 2'd3) ? calm_r : calm_r + 2'd1);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------------------------------
	// Assertions
	// --------------------------------
	cmp_drive_a: assert property (md == 2'b00 |-> !timer_out_en_n)
		else $error("pin not driven in compare mode");
	pwm_drive_a: assert property (md == 2'b10 |-> !timer_out_en_n)
		else $error("pin not driven in pwm mode");
	tmr_release_a: assert property (md == 2'b11 |-> timer_out_en_n)
		else $error("pin driven in timer mode");
	// Enable edge, then pin state one edge later, then the output flop one more
	init_level_a: assert property (wr && paddr == `CT_OFS_CTRL0 && pwdata[3] && !on_r && md == 2'b00
		|-> ##3 timer_out == (oc ^ pol)) else $error("pin missed initial level");
	hold_none_a: assert property (hold && md == 2'b00 && io == 2'b00 |-> $stable(timer_out))
		else $error("pin moved with no action");
	low_no_rise_a: assert property (hold && md == 2'b00 && io == 2'b01 |-> !$rose(timer_out))
		else $error("pin rose under low action");
	high_no_fall_a: assert property (hold && md == 2'b00 && io == 2'b10 |-> !$fell(timer_out))
		else $error("pin fell under high action");
	pwm_inactive_a: assert property (hold && md == 2'b10 && io == 2'b00 |-> timer_out == (!oc ^ pol))
		else $error("forced inactive level wrong");
	pwm_active_a: assert property (hold && md == 2'b10 && io == 2'b01 |-> timer_out == (oc ^ pol))
		else $error("forced active level wrong");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error flag outside access phase");
	// Every access outside the five register words must report an error
	err_unmapped_a: assert property (psel && penable && paddr != `CT_OFS_CTRL0 && paddr != `CT_OFS_CTRL1 &&
		paddr != `CT_OFS_CNT && paddr != `CT_OFS_CMPA && paddr != `CT_OFS_STAT |-> pslverr)
		else $error("unmapped access without error");
	cover property (hold && md == 2'b00 && io == 2'b11 && $changed(timer_out));
	cover property (hold && md == 2'b10 && io == 2'b10 && $rose(timer_out));
	cover property (pslverr);
endmodule // compact_timer_asserts
bind compact_timer compact_timer_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .timer_out(timer_out), .timer_out_en_n(timer_out_en_n));
`default_nettype wire

// ### tb/compact_timer_tb.sv
// Self-checking bench for the compact timer
`timescale 1ns/1ps
`default_nettype none
`include "compact_timer_consts.vh"
module compact_timer_tb;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	wire [31:0] prdata;
	wire pready, pslverr, timer_out, timer_out_en_n;
	int errors, checks, seed, n, hi, d;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	compact_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_out(timer_out), .timer_out_en_n(timer_out_en_n));
	// 40 MHz clock
	always #12.5 pclk = ~pclk;
	// --------------------------------
	// Checking and closing
	// --------------------------------
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Read results are matched against the oldest note when the access completes
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected read", 32'h1, 32'h0);
			else chk("read data", exp_q.pop_front(), prdata & msk_q.pop_front());
		end
	end
	// --------------------------------
	// Bus and scenario tasks
	// --------------------------------
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dat);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		// A slave that never answers ends the run as a failure
		if (n >= 20) begin
			errors++;
			complete_run();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		apb(a, 1'b0, 32'h0);
	endtask
	function automatic logic [31:0] c1(input int m, io, oc, pol, sw, cl);
		return {24'h0, 2'(m), 2'(io), 1'(oc), 1'(pol), 1'(sw), 1'(cl)};
	endfunction
	// Stop, configure, clear flags, restart; divider 0 ticks every pclk
	task automatic cfg(input logic [31:0] ctl, input int a, input logic [2:0] rp);
		apb(`CT_OFS_CTRL0, 1'b1, {29'h0, rp});
		apb(`CT_OFS_CTRL1, 1'b1, ctl);
		apb(`CT_OFS_CMPA, 1'b1, 32'(a));
		apb(`CT_OFS_STAT, 1'b1, 32'h3);
		apb(`CT_OFS_CTRL0, 1'b1, {28'h0, 1'b1, rp});
	endtask
	task automatic run(input logic [31:0] ctl, input int a, input logic [2:0] rp, input int cyc,
		input logic [2:0] e, input logic [2:0] m);
		cfg(ctl, a, rp);
		repeat (cyc) @(posedge pclk);
		apb(`CT_OFS_CTRL0, 1'b1, {29'h0, rp});
		rd(`CT_OFS_STAT, {29'h0, e}, {29'h0, m});
		$display("flag test done");
	endtask
	// Counts high samples over a whole number of periods
	task automatic pc(input logic [31:0] ctl, input int a, input logic [2:0] rp, input int len, input int e);
		cfg(ctl, a, rp);
		repeat (300) @(posedge pclk);
		hi = 0;
		repeat (len) begin
			@(posedge pclk);
			if (timer_out === 1'b1) hi++;
		end
		chk("pwm high count", 32'(e), 32'(hi));
		$display("pwm test done");
	endtask
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		errors = 0;
		checks = 0;
		seed = 32'h1dc2;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0, 32'hffffffff);
		rd(12'h800 | 12'($random(seed) & 32'h7fc), 32'h0, 32'hffffffff);
		$display("reset test done");
		for (int io = 0; io < 4; io++) begin
			run(c1(0, io, 1, 0, 0, 0), 100, 3'd1, 150, {!io[0], 2'b11}, 3'b111);
			run(c1(3, io, 1, 0, 0, 0), 100, 3'd1, 150, 3'b011, 3'b011);
		end
		run(c1(0, 1, 1, 0, 0, 1), 200, 3'd1, 300, 3'b001, 3'b111);
		run(c1(0, 3, 1, 0, 0, 0), 0, 3'd0, 1100, 3'b100, 3'b101);
		for (int io = 0; io < 2; io++) run(c1(2, io, 1, 0, 0, $random(seed) & 1), 64, 3'd2, 600, 3'b011, 3'b011);
		d = ($random(seed) & 32'hff) | 1;
		pc(c1(2, 2, 1, 0, 0, 0), d, 3'd2, 1024, 4 * d);
		pc(c1(2, 2, 1, 0, 1, 0), 300, 3'd1, 1200, 512);
		pc(c1(2, 2, 1, 1, 0, 0), 500, 3'd1, 512, 0);
		complete_run();
	end
endmodule // compact_timer_tb
`default_nettype wire
